/* include/lcd_pkg.sv */
package lcd_pkg;

   // display ram geometry
   localparam int COLS = 132;
   localparam int PAGES = 9;
   localparam logic [7:0] COL_LAST = 8'h83;
   localparam logic [7:0] COL_ZERO = 8'h00;
   localparam logic [7:0] COL_ONE = 8'h01;
   localparam logic [3:0] PAGE_IND = 4'h8;
   localparam logic [3:0] PAGE_ZERO = 4'h0;
   localparam int FIFO_DEPTH = 32;

   // initialization time after either kind of reset
   localparam int CLK_PERIOD_NS = 40;
   localparam int RESET_TIME_NS = 1000;
   localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] RESET_LOAD = 8'(RESET_CYCLES - 1);
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;

   // command codes and compare masks
   localparam logic [7:0] CMD_DISP = 8'hAE;
   localparam logic [7:0] CMD_LINE = 8'h40;
   localparam logic [7:0] CMD_PAGE = 8'hB0;
   localparam logic [7:0] CMD_COLH = 8'h10;
   localparam logic [7:0] CMD_COLL = 8'h00;
   localparam logic [7:0] CMD_SEG = 8'hA0;
   localparam logic [7:0] CMD_INV = 8'hA6;
   localparam logic [7:0] CMD_ALL = 8'hA4;
   localparam logic [7:0] CMD_BIAS = 8'hA2;
   localparam logic [7:0] CMD_RMW = 8'hE0;
   localparam logic [7:0] CMD_END = 8'hEE;
   localparam logic [7:0] CMD_RST = 8'hE2;
   localparam logic [7:0] CMD_COM = 8'hC0;
   localparam logic [7:0] CMD_PWR = 8'h28;
   localparam logic [7:0] MASK_BIT = 8'hFE;
   localparam logic [7:0] MASK_NIB = 8'hF0;
   localparam logic [7:0] MASK_LINE = 8'hC0;
   localparam logic [7:0] MASK_PWR = 8'hF8;
   localparam logic [7:0] MASK_ALL = 8'hFF;
   localparam int COM_DIR_BIT = 3;

   // status byte layout
   localparam int ST_BUSY = 7;
   localparam int ST_SEG = 6;
   localparam int ST_OFF = 5;
   localparam int ST_RST = 4;

   // power control bits
   localparam int PWR_FOLLOW = 0;
   localparam int PWR_REG = 1;
   localparam int PWR_BOOST = 2;

   // bias denominators indexed by duty strap: 0=1/65 1=1/55 2=1/49 3=1/33
   localparam logic [3:0] BIAS_LO [4] = '{4'h9, 4'h8, 4'h8, 4'h6};
   localparam logic [3:0] BIAS_HI [4] = '{4'h7, 4'h6, 4'h6, 4'h5};

   typedef struct packed {
      logic res_n;
      logic serial_sel;
      logic cs_n;
      logic dc;
      logic rd_n;
      logic wr_n;
      logic sclk;
      logic sdata;
      logic [1:0] duty;
      logic [7:0] data;
   } pin_t;

   localparam pin_t PIN_IDLE = '{res_n: 1'b1, serial_sel: 1'b0, cs_n: 1'b1, dc: 1'b0,
                                 rd_n: 1'b1, wr_n: 1'b1, sclk: 1'b0, sdata: 1'b0,
                                 duty: 2'h0, data: 8'h00};

   typedef struct packed {
      logic dc;
      logic [7:0] data;
   } host_word_t;

   typedef struct packed {
      logic display_on;
      logic seg_rev;
      logic invert;
      logic entire_on;
      logic bias_sel;
      logic com_rev;
      logic [2:0] power;
      logic [5:0] start_line;
      logic rmw;
      logic [3:0] page;
      logic [7:0] col;
      logic [7:0] col_save;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{display_on: 1'b0, seg_rev: 1'b0, invert: 1'b0,
                                    entire_on: 1'b0, bias_sel: 1'b0, com_rev: 1'b0,
                                    power: 3'h0, start_line: 6'h00, rmw: 1'b0,
                                    page: 4'h0, col: 8'h00, col_save: 8'h00};

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_INIT = 2'b10
   } init_state_t;

endpackage

/* rtl/lcd_command_decoder.sv */
`timescale 1ns/1ps
// Behaviour
// - set-page command loads 4-bit page, pages 0 to 8.
// - writes to page 8 change only bit 0.
// - column address built from upper and lower nibble commands, range 0..131.
// - each data write, and each data read outside read-modify-write, increments column, page untouched, up to last column.
// - status bit 7 is busy; commands while busy are rejected.
// - status bit 6 high for normal segment order, low for reversed.
// - status bit 5 low when display on, high when off.
// - status bit 4 high during reset initialization; low nibble zero.
// - data write stores byte at page and column, then column advances.
// - serial mode has no display data read path.
// - segment direction bit low normal, high reversed.
// - inverse bit lights pixels whose ram bit is zero; ram unchanged.
// - entire-on forces all pixels on, overriding inverse, ram kept.
// - entire-on while display off means power save.
// - bias bit picks bias ratio per duty, 1/9 or 1/7 at 1/65.
// - read-modify-write: column advances on writes only until End.
// - End leaves read-modify-write and restores the saved column.
// - reset command clears start line, column, page, common scan; ram kept.
// - common scan bit 3 low first-to-last, high last-to-first.
// - power control loads follower, regulator, booster enable bits.
// - reset pin low clears column, page, turns display off.
// - serial bytes shift in most significant bit first.
module lcd_command_decoder #(
   parameter int DEPTH = lcd_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic hard_reset_pin_n_i,
   input wire logic serial_sel_i,
   input wire logic cs_n_i,
   input wire logic cmd_data_select_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [7:0] data_i,
   input wire logic sclk_i,
   input wire logic sdata_i,
   input wire logic [1:0] duty_sel_i,
   input wire logic [3:0] scan_page_i,
   input wire logic [7:0] scan_seg_i,
   output logic [7:0] data_o,
   output logic data_oe_n_o,
   output logic busy_o,
   output logic display_on_o,
   output logic seg_reverse_o,
   output logic invert_o,
   output logic entire_on_o,
   output logic power_save_o,
   output logic com_reverse_o,
   output logic [3:0] bias_denom_o,
   output logic [2:0] power_ctrl_o,
   output logic [5:0] start_line_o,
   output logic [7:0] pixel_byte_o
);

   function automatic logic cmd_hit(input logic [7:0] b, input logic [7:0] code,
                                    input logic [7:0] mask);
      cmd_hit = (b & mask) == code;
   endfunction

   function automatic logic [7:0] col_step(input logic [7:0] c);
      col_step = (c < lcd_pkg::COL_LAST) ? c + lcd_pkg::COL_ONE : c;
   endfunction

   // pin synchroniser: three stages, change taken once stages two and three agree
   lcd_pkg::pin_t pin_raw;
   lcd_pkg::pin_t pin_s1_reg;
   lcd_pkg::pin_t pin_s2_reg;
   lcd_pkg::pin_t pin_s3_reg;
   lcd_pkg::pin_t pin_reg;
   lcd_pkg::pin_t pin_prev_reg;
   lcd_pkg::pin_t pin_next;
   lcd_pkg::pin_t pin_diff;

   assign pin_raw = {hard_reset_pin_n_i, serial_sel_i, cs_n_i, cmd_data_select_i, rd_n_i,
                     wr_n_i, sclk_i, sdata_i, duty_sel_i, data_i};
   assign pin_diff = pin_s2_reg ^ pin_s3_reg;
   assign pin_next = (pin_s3_reg & ~pin_diff) | (pin_reg & pin_diff);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1_reg <= lcd_pkg::PIN_IDLE;
         pin_s2_reg <= lcd_pkg::PIN_IDLE;
         pin_s3_reg <= lcd_pkg::PIN_IDLE;
         pin_reg <= lcd_pkg::PIN_IDLE;
         pin_prev_reg <= lcd_pkg::PIN_IDLE;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_reg <= pin_next;
         pin_prev_reg <= pin_reg;
      end
   end

   // host strobe events
   wire hard_rst = ~pin_reg.res_n;
   wire par_sel = ~pin_reg.serial_sel & ~pin_reg.cs_n;
   wire wr_event = par_sel & pin_reg.wr_n & ~pin_prev_reg.wr_n;
   wire rd_active = par_sel & ~pin_reg.rd_n;
   wire rd_start = rd_active & pin_prev_reg.rd_n;
   wire rd_end = par_sel & pin_reg.rd_n & ~pin_prev_reg.rd_n;
   wire rd_end_data = rd_end & pin_reg.dc;
   wire ser_sel = pin_reg.serial_sel & ~pin_reg.cs_n;
   wire sclk_rise = ser_sel & pin_reg.sclk & ~pin_prev_reg.sclk;

   // serial shifter
   logic [7:0] shift_reg;
   logic [2:0] bit_cnt_reg;
   wire [7:0] shift_next = {shift_reg[6:0], pin_reg.sdata};
   wire ser_byte = sclk_rise & (bit_cnt_reg == 3'h7);

   always_ff @(posedge clk_i) begin
      if (rst_i | ~ser_sel) begin
         shift_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
      end else if (sclk_rise) begin
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   // command fifo between host pins and executor
   lcd_pkg::host_word_t push_word;
   lcd_pkg::host_word_t pop_word;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic pop_ready;
   lcd_pkg::init_state_t state_reg;
   lcd_pkg::init_state_t state_next;
   logic [7:0] init_cnt_reg;
   logic [7:0] init_cnt_next;

   wire init_busy = state_reg == lcd_pkg::ST_INIT;
   // full fifo shows as busy so the host is throttled
   wire busy = init_busy | ~fifo_in_ready;
   assign push_word = pin_reg.serial_sel ? {pin_reg.dc, shift_next} : {pin_reg.dc, pin_reg.data};
   wire push_valid = (wr_event | ser_byte) & ~busy & ~hard_rst;
   // reads own the column for their cycle, so the executor waits
   assign pop_ready = ~init_busy & ~rd_active & ~rd_end & ~hard_rst;
   wire pop = pop_ready & fifo_out_valid;

   word_fifo #(
      .WIDTH($bits(lcd_pkg::host_word_t)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i | hard_rst),
      .in_data_i(push_word),
      .in_valid_i(push_valid),
      .in_ready_o(fifo_in_ready),
      .out_data_o(pop_word),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(pop_ready)
   );

   // command decode
   wire [7:0] op = pop_word.data;
   wire cmd = pop & ~pop_word.dc;
   wire wr_data = pop & pop_word.dc;
   wire c_disp = cmd & cmd_hit(op, lcd_pkg::CMD_DISP, lcd_pkg::MASK_BIT);
   wire c_line = cmd & cmd_hit(op, lcd_pkg::CMD_LINE, lcd_pkg::MASK_LINE);
   wire c_page = cmd & cmd_hit(op, lcd_pkg::CMD_PAGE, lcd_pkg::MASK_NIB);
   wire c_colh = cmd & cmd_hit(op, lcd_pkg::CMD_COLH, lcd_pkg::MASK_NIB);
   wire c_coll = cmd & cmd_hit(op, lcd_pkg::CMD_COLL, lcd_pkg::MASK_NIB);
   wire c_seg = cmd & cmd_hit(op, lcd_pkg::CMD_SEG, lcd_pkg::MASK_BIT);
   wire c_inv = cmd & cmd_hit(op, lcd_pkg::CMD_INV, lcd_pkg::MASK_BIT);
   wire c_all = cmd & cmd_hit(op, lcd_pkg::CMD_ALL, lcd_pkg::MASK_BIT);
   wire c_bias = cmd & cmd_hit(op, lcd_pkg::CMD_BIAS, lcd_pkg::MASK_BIT);
   wire c_rmw = cmd & cmd_hit(op, lcd_pkg::CMD_RMW, lcd_pkg::MASK_ALL);
   wire c_end = cmd & cmd_hit(op, lcd_pkg::CMD_END, lcd_pkg::MASK_ALL);
   wire c_rst = cmd & cmd_hit(op, lcd_pkg::CMD_RST, lcd_pkg::MASK_ALL);
   wire c_com = cmd & cmd_hit(op, lcd_pkg::CMD_COM, lcd_pkg::MASK_NIB);
   wire c_pwr = cmd & cmd_hit(op, lcd_pkg::CMD_PWR, lcd_pkg::MASK_PWR);

   lcd_pkg::ctrl_t ctrl_reg;
   lcd_pkg::ctrl_t ctrl_next;

   always_comb begin
      ctrl_next = ctrl_reg;
      if (hard_rst) begin
         ctrl_next = lcd_pkg::CTRL_RESET;
      end else if (rd_end_data) begin
         if (!ctrl_reg.rmw) begin
            ctrl_next.col = col_step(ctrl_reg.col);
         end
      end else if (wr_data) begin
         ctrl_next.col = col_step(ctrl_reg.col);
      end else if (cmd) begin
         if (c_disp) begin
            ctrl_next.display_on = op[0];
         end
         if (c_line) begin
            ctrl_next.start_line = op[5:0];
         end
         if (c_page && op[3:0] <= lcd_pkg::PAGE_IND) begin
            ctrl_next.page = op[3:0];
         end
         if (c_colh) begin
            ctrl_next.col = {op[3:0], ctrl_reg.col[3:0]};
         end
         if (c_coll) begin
            ctrl_next.col = {ctrl_reg.col[7:4], op[3:0]};
         end
         if (c_seg) begin
            ctrl_next.seg_rev = op[0];
         end
         if (c_inv) begin
            ctrl_next.invert = op[0];
         end
         if (c_all) begin
            ctrl_next.entire_on = op[0];
         end
         if (c_bias) begin
            ctrl_next.bias_sel = op[0];
         end
         if (c_com) begin
            ctrl_next.com_rev = op[lcd_pkg::COM_DIR_BIT];
         end
         if (c_pwr) begin
            ctrl_next.power = op[2:0];
         end
         if (c_rmw) begin
            ctrl_next.rmw = 1'b1;
            ctrl_next.col_save = ctrl_reg.col;
         end
         if (c_end && ctrl_reg.rmw) begin
            ctrl_next.rmw = 1'b0;
            ctrl_next.col = ctrl_reg.col_save;
         end
         // command reset, display and power kept
         if (c_rst) begin
            ctrl_next.start_line = lcd_pkg::CTRL_RESET.start_line;
            ctrl_next.col = lcd_pkg::COL_ZERO;
            ctrl_next.page = lcd_pkg::PAGE_ZERO;
            ctrl_next.com_rev = lcd_pkg::CTRL_RESET.com_rev;
            ctrl_next.bias_sel = lcd_pkg::CTRL_RESET.bias_sel;
            ctrl_next.rmw = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= lcd_pkg::CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // initialization sequencer
   always_comb begin
      state_next = state_reg;
      init_cnt_next = init_cnt_reg;
      unique case (state_reg)
         lcd_pkg::ST_RUN: begin
            if (hard_rst || c_rst) begin
               state_next = lcd_pkg::ST_INIT;
               init_cnt_next = lcd_pkg::RESET_LOAD;
            end
         end
         lcd_pkg::ST_INIT: begin
            if (hard_rst) begin
               init_cnt_next = lcd_pkg::RESET_LOAD;
            end else if (init_cnt_reg == lcd_pkg::CNT_ZERO) begin
               state_next = lcd_pkg::ST_RUN;
            end else begin
               init_cnt_next = init_cnt_reg - lcd_pkg::CNT_ONE;
            end
         end
         default: begin
            state_next = lcd_pkg::ST_INIT;
            init_cnt_next = lcd_pkg::RESET_LOAD;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= lcd_pkg::ST_INIT;
         init_cnt_reg <= lcd_pkg::RESET_LOAD;
      end else begin
         state_reg <= state_next;
         init_cnt_reg <= init_cnt_next;
      end
   end

   // display ram, kept across both kinds of reset
   logic [7:0] ram [lcd_pkg::PAGES][lcd_pkg::COLS];
   logic [7:0] read_latch_reg;
   wire addr_ok = (ctrl_reg.page <= lcd_pkg::PAGE_IND) && (ctrl_reg.col <= lcd_pkg::COL_LAST);
   wire [7:0] ram_cur = addr_ok ? ram[ctrl_reg.page][ctrl_reg.col] : 8'h00;
   wire ind_page = ctrl_reg.page == lcd_pkg::PAGE_IND;
   wire [7:0] wr_byte = ind_page ? {ram_cur[7:1], pop_word.data[0]} : pop_word.data;

   always_ff @(posedge clk_i) begin
      if (wr_data && addr_ok) begin
         ram[ctrl_reg.page][ctrl_reg.col] <= wr_byte;
      end
   end

   // read latch is refilled at the end of each data read, hence the dummy read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         read_latch_reg <= 8'h00;
      end else if (rd_end_data) begin
         read_latch_reg <= ram_cur;
      end
   end

   // status byte
   logic [7:0] status;
   always_comb begin
      status = 8'h00;
      status[lcd_pkg::ST_BUSY] = busy;
      status[lcd_pkg::ST_SEG] = ~ctrl_reg.seg_rev;
      status[lcd_pkg::ST_OFF] = ~ctrl_reg.display_on;
      status[lcd_pkg::ST_RST] = init_busy;
   end

   // display scan port
   wire [7:0] scan_col = ctrl_reg.seg_rev ? lcd_pkg::COL_LAST - scan_seg_i : scan_seg_i;
   wire scan_ok = (scan_page_i <= lcd_pkg::PAGE_IND) && (scan_col <= lcd_pkg::COL_LAST);
   wire [7:0] scan_raw = scan_ok ? ram[scan_page_i][scan_col] : 8'h00;
   wire [7:0] pixel_next = ctrl_reg.entire_on ? 8'hFF : (ctrl_reg.invert ? ~scan_raw : scan_raw);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_o <= 8'h00;
         data_oe_n_o <= 1'b1;
         pixel_byte_o <= 8'h00;
         bias_denom_o <= lcd_pkg::BIAS_LO[0];
      end else begin
         if (rd_start) begin
            data_o <= pin_reg.dc ? read_latch_reg : status;
         end
         data_oe_n_o <= ~rd_active;
         pixel_byte_o <= pixel_next;
         bias_denom_o <= ctrl_reg.bias_sel ? lcd_pkg::BIAS_HI[pin_reg.duty] :
                                             lcd_pkg::BIAS_LO[pin_reg.duty];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b1;
         display_on_o <= 1'b0;
         seg_reverse_o <= 1'b0;
         invert_o <= 1'b0;
         entire_on_o <= 1'b0;
         power_save_o <= 1'b0;
         com_reverse_o <= 1'b0;
         power_ctrl_o <= 3'h0;
         start_line_o <= 6'h00;
      end else begin
         busy_o <= busy;
         display_on_o <= ctrl_reg.display_on;
         seg_reverse_o <= ctrl_reg.seg_rev;
         invert_o <= ctrl_reg.invert;
         entire_on_o <= ctrl_reg.entire_on;
         power_save_o <= ctrl_reg.entire_on & ~ctrl_reg.display_on;
         com_reverse_o <= ctrl_reg.com_rev;
         power_ctrl_o <= ctrl_reg.power;
         start_line_o <= ctrl_reg.start_line;
      end
   end

endmodule

/* rtl/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;
   // extra pointer bit tells full from empty
   wire ptr_same = wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0];

   assign out_valid_o = ~(ptr_same & (wr_ptr_reg[AW] == rd_ptr_reg[AW]));
   assign in_ready_o = ~(ptr_same & (wr_ptr_reg[AW] != rd_ptr_reg[AW]));
   assign out_data_o = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
         rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
      end
   end
endmodule

/* verif/lcd_command_decoder_checker.sv */
`timescale 1ns/1ps
module lcd_command_decoder_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic hard_reset_pin_n_i,
   input wire logic serial_sel_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic [1:0] duty_sel_i,
   input wire logic data_oe_n_o,
   input wire logic busy_o,
   input wire logic display_on_o,
   input wire logic entire_on_o,
   input wire logic power_save_o,
   input wire logic [3:0] bias_denom_o,
   input wire logic [7:0] pixel_byte_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_init_busy;
      $fell(rst_i) |-> busy_o [*8];
   endproperty
   a_init_busy: assert property (p_init_busy) else $error("busy low during init");
   property p_init_end;
      $fell(rst_i) |-> ##[20:40] !busy_o;
   endproperty
   a_init_end: assert property (p_init_end) else $error("init did not end");
   property p_psave;
      ($stable(entire_on_o) && $stable(display_on_o)) [*2] |->
         power_save_o == (entire_on_o && !display_on_o);
   endproperty
   a_psave: assert property (p_psave) else $error("power save wrong");
   property p_bias;
      // strap passes the pin filter first, so only look once it has settled
      !$past(rst_i, 6) && duty_sel_i == $past(duty_sel_i, 6) |->
         bias_denom_o == lcd_pkg::BIAS_LO[duty_sel_i]
         || bias_denom_o == lcd_pkg::BIAS_HI[duty_sel_i];
   endproperty
   a_bias: assert property (p_bias) else $error("bias off table");
   property p_ser_quiet;
      serial_sel_i [*8] |-> data_oe_n_o;
   endproperty
   a_ser_quiet: assert property (p_ser_quiet) else $error("serial mode drives bus");
   property p_rd_drive;
      ($fell(rd_n_i) && !cs_n_i && !serial_sel_i) ##1 !rd_n_i [*7] |-> !data_oe_n_o;
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
   property p_rd_release;
      $rose(rd_n_i) |-> ##[1:8] data_oe_n_o;
   endproperty
   a_rd_release: assert property (p_rd_release) else $error("bus not released");
   property p_entire;
      entire_on_o && $past(entire_on_o) |-> pixel_byte_o == 8'hFF;
   endproperty
   a_entire: assert property (p_entire) else $error("entire on not lit");
   property p_hard;
      !hard_reset_pin_n_i [*8] |-> busy_o && !display_on_o;
   endproperty
   a_hard: assert property (p_hard) else $error("pin reset ignored");
endmodule
bind lcd_command_decoder lcd_command_decoder_checker chk (.clk_i(clk_i), .rst_i(rst_i),
   .hard_reset_pin_n_i(hard_reset_pin_n_i), .serial_sel_i(serial_sel_i), .cs_n_i(cs_n_i),
   .rd_n_i(rd_n_i), .duty_sel_i(duty_sel_i), .data_oe_n_o(data_oe_n_o), .busy_o(busy_o),
   .display_on_o(display_on_o), .entire_on_o(entire_on_o), .power_save_o(power_save_o),
   .bias_denom_o(bias_denom_o), .pixel_byte_o(pixel_byte_o));

/* verif/lcd_command_decoder_test.sv */
`timescale 1ns/1ps
module lcd_command_decoder_test;
   typedef struct packed {
      logic [2:0] sel;
      logic [7:0] val;
   } note_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic chk = 1'b0;
   logic [3:0] sp = 4'h0;
   logic [7:0] ss = 8'h00;
   logic [7:0] dout, pix, rdd, d0, d1, d2, rcol;
   logic [5:0] line;
   logic [3:0] bias, rpg;
   logic [2:0] pwr;
   logic [1:0] duty;
   logic oe_n, busy, on, seg, inv, all, ps, comr;
   lcd_pkg::pin_t p;
   note_t notes[$];
   note_t m;
   int fail_count = 0;
   int num_checks = 0;
   always #20 clk_i = ~clk_i;
   lcd_command_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .hard_reset_pin_n_i(p.res_n),
      .serial_sel_i(p.serial_sel), .cs_n_i(p.cs_n), .cmd_data_select_i(p.dc), .rd_n_i(p.rd_n),
      .wr_n_i(p.wr_n), .data_i(p.data), .sclk_i(p.sclk), .sdata_i(p.sdata),
      .duty_sel_i(p.duty), .scan_page_i(sp), .scan_seg_i(ss), .data_o(dout),
      .data_oe_n_o(oe_n), .busy_o(busy), .display_on_o(on), .seg_reverse_o(seg),
      .invert_o(inv), .entire_on_o(all), .power_save_o(ps), .com_reverse_o(comr),
      .bias_denom_o(bias), .power_ctrl_o(pwr), .start_line_o(line), .pixel_byte_o(pix));
   lcd_host_model host (.clk_i(clk_i), .data_i(dout), .pins_o(p), .rd_data_o(rdd));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      if (chk) begin
         m = notes.pop_front();
         case (m.sel)
            0: check("pixel", pix, m.val);
            1: check("read", rdd, m.val);
            2: check("flags", {busy, on, seg, inv, all, ps, comr, 1'b0}, m.val);
            3: check("line", {2'b00, line}, m.val);
            5: check("indicator", {7'h00, pix[0]}, m.val);
            default: check("power", {1'b0, pwr, bias}, m.val);
         endcase
      end
   end
   task automatic note(input logic [2:0] s, input logic [7:0] v);
      notes.push_back('{s, v});
      chk = 1'b1;
      @(negedge clk_i);
      chk = 1'b0;
   endtask
   task automatic c(input logic [7:0] v);
      host.wr(1'b0, v);
   endtask
   task automatic dw(input logic [7:0] v);
      host.wr(1'b1, v);
   endtask
   task automatic pc(input logic [3:0] pg, input logic [7:0] col);
      c({4'hB, pg});
      c({4'h1, col[7:4]});
      c({4'h0, col[3:0]});
   endtask
   task automatic px(input logic [3:0] pg, input logic [7:0] sg, input logic [7:0] v);
      sp = pg;
      ss = sg;
      @(negedge clk_i);
      note(3'd0, v);
   endtask
   task automatic idle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 500) begin
         @(negedge clk_i);
         k++;
      end
      if (k == 500) fail_count++;
   endtask
   initial begin
      #400000;
      fail_count++;
      summarize();
   end
   initial begin
      void'($urandom(32'h2E8859DE));
      duty = 2'($urandom);
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      rpg = 4'($urandom % 8);
      rcol = 8'($urandom % lcd_pkg::COLS);
      repeat (16) @(negedge clk_i);
      host.pins_o.duty = duty;
      rst_i = 1'b0;
      idle();
      note(3'd2, 8'h00);
      note(3'd4, {4'h0, lcd_pkg::BIAS_LO[duty]});
      host.rd(1'b0);
      note(3'd1, 8'h60);
      pc(4'h2, 8'h82);
      dw(d0);
      dw(d1);
      px(4'h2, 8'h82, d0);
      px(4'h2, 8'h83, d1);
      pc(4'h1, 8'h00);
      c(8'hB9);
      dw(d2);
      px(4'h1, 8'h00, d2);
      pc(4'h8, 8'h05);
      dw(8'h01);
      sp = 4'h8;
      ss = 8'h05;
      @(negedge clk_i);
      note(3'd5, 8'h01);
      pc(4'h8, 8'h05);
      dw(8'hFE);
      @(negedge clk_i);
      note(3'd5, 8'h00);
      pc(4'h3, 8'h0A);
      dw(8'h00);
      dw(8'h00);
      dw(8'h00);
      pc(4'h3, 8'h0A);
      c(8'hE0);
      host.rd(1'b1);
      host.rd(1'b1);
      dw(d0);
      c(8'hEE);
      dw(d1);
      px(4'h3, 8'h0A, d1);
      px(4'h3, 8'h0C, 8'h00);
      pc(4'h3, 8'h0A);
      // dummy read after column set
      host.rd(1'b1);
      host.rd(1'b1);
      note(3'd1, d1);
      host.rd(1'b1);
      note(3'd1, 8'h00);
      c(8'hA7);
      px(4'h3, 8'h0A, ~d1);
      c(8'hA5);
      note(3'd2, 8'h1C);
      c(8'hAF);
      note(3'd2, 8'h58);
      c(8'hA4);
      c(8'hA6);
      c(8'hA1);
      px(4'h3, 8'h79, d1);
      host.rd(1'b0);
      note(3'd1, 8'h00);
      c(8'hA0);
      for (int i = 0; i < 8; i++) begin
         c({5'b00101, 3'(i)});
         note(3'd4, {1'b0, 3'(i), lcd_pkg::BIAS_LO[duty]});
      end
      c(8'hA3);
      c(8'hC8);
      c(8'h45);
      note(3'd4, {4'h7, lcd_pkg::BIAS_HI[duty]});
      note(3'd3, 8'h05);
      note(3'd2, 8'h42);
      c(8'hE2);
      c(8'hA7);
      idle();
      note(3'd2, 8'h40);
      note(3'd3, 8'h00);
      note(3'd4, {4'h7, lcd_pkg::BIAS_LO[duty]});
      dw(d2);
      px(4'h0, 8'h00, d2);
      host.pins_o.serial_sel = 1'b1;
      host.ser(1'b0, 8'hAE);
      host.ser(1'b1, d0);
      host.rd(1'b1);
      note(3'd2, 8'h00);
      px(4'h0, 8'h01, d0);
      host.pins_o.serial_sel = 1'b0;
      c(8'hAF);
      host.pins_o.res_n = 1'b0;
      repeat (10) @(negedge clk_i);
      note(3'd2, 8'h80);
      host.pins_o.res_n = 1'b1;
      idle();
      dw(d1);
      px(4'h0, 8'h00, d1);
      px(4'h3, 8'h0A, d1);
      // deselected strobes must not move the column
      host.noise(40);
      dw(d2);
      px(4'h0, 8'h01, d2);
      pc(rpg, rcol);
      dw(d0);
      px(rpg, rcol, d0);
      summarize();
   end
endmodule

/* verif/lcd_host_model.sv */
`timescale 1ns/1ps
module lcd_host_model (
   input wire logic clk_i,
   input wire logic [7:0] data_i,
   output lcd_pkg::pin_t pins_o,
   output logic [7:0] rd_data_o
);
   initial begin
      pins_o = lcd_pkg::PIN_IDLE;
      rd_data_o = 8'h00;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // released bus shows inverse, never the last value
   task automatic wr(input logic dc, input logic [7:0] d);
      pins_o.cs_n = 1'b0;
      pins_o.dc = dc;
      pins_o.data = d;
      pins_o.wr_n = 1'b0;
      hold(6);
      pins_o.wr_n = 1'b1;
      hold(6);
      pins_o.cs_n = 1'b1;
      pins_o.data = ~d;
      hold(2);
   endtask
   task automatic rd(input logic dc);
      pins_o.cs_n = 1'b0;
      pins_o.dc = dc;
      pins_o.rd_n = 1'b0;
      hold(8);
      rd_data_o = data_i;
      pins_o.rd_n = 1'b1;
      hold(6);
      pins_o.cs_n = 1'b1;
      hold(2);
   endtask
   // deselected strobes toggle at random and must be ignored
   task automatic noise(input int n);
      for (int i = 0; i < n; i++) begin
         {pins_o.wr_n, pins_o.rd_n, pins_o.dc, pins_o.sclk} = 4'($urandom);
         hold(1);
      end
      pins_o.wr_n = 1'b1;
      pins_o.rd_n = 1'b1;
      pins_o.sclk = 1'b0;
      hold(6);
   endtask
   task automatic ser(input logic dc, input logic [7:0] d);
      pins_o.cs_n = 1'b0;
      pins_o.dc = dc;
      for (int i = 7; i >= 0; i--) begin
         pins_o.sdata = d[i];
         hold(6);
         pins_o.sclk = 1'b1;
         hold(6);
         pins_o.sclk = 1'b0;
      end
      hold(6);
      pins_o.cs_n = 1'b1;
      pins_o.sdata = ~d[0];
      hold(2);
   endtask
endmodule
